/* File: logic/aph_fifo.sv */
// sample fifo with valid/ready on both sides and a flush
`timescale 1ns/10ps
module aph_fifo #(
	parameter int unsigned WIDTH = 12,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire logic                       flush,
	input  wire logic [WIDTH-1:0]           in_data,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	output logic [WIDTH-1:0]                out_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [CW-1:0]    count_reg;
	wire              push;
	wire              pop;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready  = (count_reg != CW'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push      = in_valid & in_ready & ~flush;
	assign pop       = out_valid & out_ready & ~flush;
	assign out_data  = mem[rd_ptr_reg];
	assign level     = count_reg;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (srst || flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) wr_ptr_reg <= ptr_inc(wr_ptr_reg);
			if (pop) rd_ptr_reg <= ptr_inc(rd_ptr_reg);
			count_reg <= count_reg + CW'(push) - CW'(pop);
		end
	end
endmodule // aph_fifo

/* File: logic/aph_host_port.sv */
// parallel host port: strobe combination, sample readout, control load
//
// Notes on behaviour
// (RULE1) read strobe needs all selects, read, no write
// (RULE2) read strobe drops with first inactive input
// (RULE3) each read pops one word, drives bus
// (RULE4) write strobe needs all selects, write, no read
// (RULE5) write strobe drops with first inactive input
// (RULE6) write loads control register zero or one
// (RULE7) write pin: write strobe or read/write direction
// (RULE8) samples leave over twelve-bit parallel bus
// (RULE9) host resets and configures before reading samples
// (RULE10) samples ready output behaviour is programmable
// (RULE11) combined mode: host holds read pin high
// (RULE12) overflow flag set on lost data, init clears
// (RULE13) bus drivers off while read strobe inactive
`timescale 1ns/10ps
module aph_host_port
	import aph_pkg::*;
#(
	parameter int unsigned DATA_WIDTH = DATA_W,
	parameter int unsigned DEPTH      = FIFO_DEPTH
) (
	input  wire logic                    clk,
	input  wire logic                    srst,
	input  wire logic                    chip_select_a_n,
	input  wire logic                    chip_select_b,
	input  wire logic                    read_n,
	input  wire logic                    write_n,
	input  wire logic                    rw_combined,
	input  wire logic [DATA_WIDTH-1:0]   parallel_data_bus_in,
	output logic [DATA_WIDTH-1:0]        parallel_data_bus_out,
	output logic                         parallel_data_bus_oe_n,
	input  wire logic [DATA_WIDTH-1:0]   sample_data,
	input  wire logic                    sample_valid,
	output logic                         sample_ready,
	output logic                         samples_ready_output,
	output logic                         overflow_flag,
	output logic [CW_PAYLOAD_W-1:0]      ctrl0_value,
	output logic [CW_PAYLOAD_W-1:0]      ctrl1_value
);
	localparam int unsigned LW = $clog2(DEPTH+1);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// pins come from the host's bus timing, so two flops each
	logic [SYNC_W-1:0]     ctl_meta_reg;
	logic [SYNC_W-1:0]     ctl_sync_reg;
	logic [DATA_WIDTH-1:0] dat_meta_reg;
	logic [DATA_WIDTH-1:0] dat_sync_reg;
	logic                  mode_meta_reg;
	logic                  mode_sync_reg;

	always_ff @(posedge clk) begin
		ctl_meta_reg  <= {chip_select_a_n, chip_select_b, read_n, write_n};
		ctl_sync_reg  <= ctl_meta_reg;
		dat_meta_reg  <= parallel_data_bus_in;
		dat_sync_reg  <= dat_meta_reg;
		mode_meta_reg <= rw_combined;
		mode_sync_reg <= mode_meta_reg;
	end

	// ------------------------------------------------------------
	// strobe combination
	// ------------------------------------------------------------
	wire sel_a_pin_n;
	wire sel_b_pin;
	wire rd_pin_n;
	wire wr_pin_n;
	wire sel_a_act;
	wire sel_b_act;
	wire rd_pin_act;
	wire wr_pin_act;
	wire both_sel;
	wire rd_want;
	wire wr_want;
	wire rd_strobe;
	wire wr_strobe;

	assign {sel_a_pin_n, sel_b_pin, rd_pin_n, wr_pin_n} = ctl_sync_reg;
	assign sel_a_act  = ~sel_a_pin_n;
	assign sel_b_act  = sel_b_pin;
	assign rd_pin_act = ~rd_pin_n;
	assign wr_pin_act = ~wr_pin_n;
	assign both_sel   = sel_a_act & sel_b_act;

	// in combined mode the write pin is a direction: high reads, low
	// writes; the read pin is expected to sit high and is ignored
	assign rd_want = mode_sync_reg ? ~wr_pin_act              // [RULE7]
	                               : (rd_pin_act & ~wr_pin_act); // [RULE1]
	assign wr_want = mode_sync_reg ? wr_pin_act               // [RULE7] [RULE11]
	                               : (wr_pin_act & ~rd_pin_act); // [RULE4]
	// any input going inactive removes the strobe at once
	assign rd_strobe = both_sel & rd_want; // [RULE1] [RULE2]
	assign wr_strobe = both_sel & wr_want; // [RULE4] [RULE5]

	logic rd_strobe_reg;
	wire  rd_rise;
	wire  wr_fall;

	always_ff @(posedge clk) begin
		if (srst) begin
			rd_strobe_reg <= 1'b0;
		end else begin
			rd_strobe_reg <= rd_strobe;
		end
	end

	assign rd_rise = rd_strobe & ~rd_strobe_reg;

	// ------------------------------------------------------------
	// sample buffer
	// ------------------------------------------------------------
	logic                  soft_reset;
	wire  [DATA_WIDTH-1:0] head_data;
	wire                   head_valid;
	wire  [LW-1:0]         fifo_level;
	wire                   pop_req;

	// no pop while flushing, else the bus would show a discarded word
	assign pop_req = rd_rise & head_valid & ~soft_reset; // [RULE3]

	aph_fifo #(
		.WIDTH (DATA_WIDTH),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (clk),
		.srst      (srst),
		.flush     (soft_reset),
		.in_data   (sample_data),
		.in_valid  (sample_valid),
		.in_ready  (sample_ready),
		.out_data  (head_data),
		.out_valid (head_valid),
		.out_ready (pop_req),
		.level     (fifo_level)
	);

	// ------------------------------------------------------------
	// read data path
	// ------------------------------------------------------------
	logic [DATA_WIDTH-1:0] dout_reg;
	logic [DATA_WIDTH-1:0] dout_next;

	// an empty read repeats the last word rather than inventing one
	assign dout_next = pop_req ? head_data : dout_reg; // [RULE3] [RULE8]

	always_ff @(posedge clk) begin
		if (srst) begin
			dout_reg <= '0;
		end else begin
			dout_reg <= dout_next;
		end
	end

	assign parallel_data_bus_out  = dout_reg;
	// drivers stay off between reads so other agents own the bus
	assign parallel_data_bus_oe_n = ~rd_strobe; // [RULE3] [RULE13]

	// ------------------------------------------------------------
	// write strobe tracking and control load
	// ------------------------------------------------------------
	aph_wr_state_t         wr_state_reg;
	aph_wr_state_t         wr_state_next;
	logic [DATA_WIDTH-1:0] wr_latch_reg;

	always_comb begin
		wr_state_next = wr_state_reg;
		case (wr_state_reg)
			APH_WR_IDLE: begin
				if (wr_strobe) wr_state_next = APH_WR_HELD;
			end
			APH_WR_HELD: begin
				if (!wr_strobe) wr_state_next = APH_WR_DONE;
			end
			APH_WR_DONE: begin
				wr_state_next = wr_strobe ? APH_WR_HELD : APH_WR_IDLE;
			end
			default: wr_state_next = APH_WR_IDLE;
		endcase
	end

	// the word is taken at the end of the strobe, last value seen
	// while it was still active
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_state_reg <= APH_WR_IDLE;
			wr_latch_reg <= '0;
		end else begin
			wr_state_reg <= wr_state_next;
			if (wr_strobe) wr_latch_reg <= dat_sync_reg;
		end
	end

	// end of a held strobe marks the one cycle in which the word lands
	assign wr_fall = ~wr_strobe & (wr_state_reg == APH_WR_HELD); // [RULE6]

	logic [CW_PAYLOAD_W-1:0] ctrl0_reg;
	logic [CW_PAYLOAD_W-1:0] ctrl1_reg;
	wire                     load0;
	wire                     load1;
	wire [CW_PAYLOAD_W-1:0]  payload;

	assign payload = wr_latch_reg[CW_PAYLOAD_W-1:0];
	assign load0   = wr_fall & ~wr_latch_reg[CW_SEL_BIT]; // [RULE6]
	assign load1   = wr_fall & wr_latch_reg[CW_SEL_BIT];  // [RULE6]

	// the reset bit gives a one-cycle soft_reset pulse, though ctrl0_reg keeps the written word, reset bit included
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl0_reg  <= CTRL0_RST;
			ctrl1_reg  <= CTRL1_RST;
			soft_reset <= 1'b0;
		end else begin
			if (load0) ctrl0_reg <= payload;
			if (load1) ctrl1_reg <= payload;
			soft_reset <= load0 & payload[C0_RESET_BIT]; // [RULE9]
		end
	end

	assign ctrl0_value = ctrl0_reg;
	assign ctrl1_value = ctrl1_reg;

	// ------------------------------------------------------------
	// overflow flag
	// ------------------------------------------------------------
	logic overflow_reg;
	wire  lost_sample;

	assign lost_sample = sample_valid & ~sample_ready;

	// a loss in the very cycle of the init still counts
	always_ff @(posedge clk) begin
		if (srst) begin
			overflow_reg <= 1'b0;
		end else if (lost_sample) begin
			overflow_reg <= 1'b1; // [RULE12]
		end else if (soft_reset) begin
			overflow_reg <= 1'b0; // [RULE12]
		end
	end

	assign overflow_flag = overflow_reg;

	// ------------------------------------------------------------
	// samples ready output
	// ------------------------------------------------------------
	aph_av_mode_t          av_mode;
	wire  [C1_TRIG_W-1:0]  trig_level;
	wire                   av_raw;
	logic                  av_reg;

	assign av_mode    = aph_av_mode_t'(ctrl1_reg[C1_MODE_BIT]);
	assign trig_level = ctrl1_reg[C1_TRIG_LSB +: C1_TRIG_W];
	assign av_raw     = (av_mode == APH_AV_TRIGGER)
	                  ? (fifo_level >= LW'(trig_level))
	                  : head_valid; // [RULE10]

	always_ff @(posedge clk) begin
		if (srst) begin
			av_reg <= 1'b0;
		end else begin
			av_reg <= av_raw ^ ctrl1_reg[C1_POL_BIT]; // [RULE10]
		end
	end

	assign samples_ready_output = av_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	rd_needs_all_a: assert property (@(posedge clk) disable iff (srst) // [RULE1]
		(rd_strobe && !mode_sync_reg) |->
			(sel_a_act && sel_b_act && rd_pin_act && !wr_pin_act))
		else $error("read strobe without full select");

	rd_drop_a: assert property (@(posedge clk) disable iff (srst) // [RULE2]
		(sel_a_pin_n || !sel_b_pin || (rd_pin_n && !mode_sync_reg)) |->
			(!rd_strobe && parallel_data_bus_oe_n))
		else $error("read strobe held after deselect");

	pop_one_a: assert property (@(posedge clk) disable iff (srst) // [RULE3]
		(rd_rise && head_valid && !soft_reset) |=> (dout_reg == $past(head_data)))
		else $error("read did not present fifo head");

	wr_needs_all_a: assert property (@(posedge clk) disable iff (srst) // [RULE4]
		(wr_strobe && !mode_sync_reg) |->
			(sel_a_act && sel_b_act && wr_pin_act && !rd_pin_act))
		else $error("write strobe without full select");

	wr_drop_a: assert property (@(posedge clk) disable iff (srst) // [RULE5]
		(sel_a_pin_n || !sel_b_pin || wr_pin_n) |-> !wr_strobe)
		else $error("write strobe held after deselect");

	ctrl_load_a: assert property (@(posedge clk) disable iff (srst) // [RULE6]
		load1 |=> (ctrl1_reg == $past(payload)) && $stable(ctrl0_reg))
		else $error("control word went to wrong register");

	combined_mode_a: assert property (@(posedge clk) disable iff (srst) // [RULE7]
		(mode_sync_reg && both_sel) |-> (rd_strobe != wr_strobe))
		else $error("combined mode strobes not exclusive");

	bus_off_a: assert property (@(posedge clk) disable iff (srst) // [RULE13]
		!rd_strobe |-> parallel_data_bus_oe_n)
		else $error("bus driven outside read");

	ovf_set_a: assert property (@(posedge clk) disable iff (srst) // [RULE12]
		lost_sample |=> overflow_flag ##1 (overflow_flag || $past(soft_reset)))
		else $error("overflow not flagged");

	ovf_clear_a: assert property (@(posedge clk) disable iff (srst) // [RULE12]
		(soft_reset && !lost_sample) |=> !overflow_flag)
		else $error("init did not clear overflow");

	av_level_a: assert property (@(posedge clk) disable iff (srst) // [RULE10]
		(av_mode == APH_AV_NOT_EMPTY && !ctrl1_reg[C1_POL_BIT]) |=>
			(samples_ready_output == ($past(fifo_level) != '0)))
		else $error("samples ready not tracking fill");

	av_follow_a: assert property (@(posedge clk) disable iff (srst) // [RULE10]
		(av_mode == APH_AV_TRIGGER) |=>
			(samples_ready_output == (($past(fifo_level) >=
				LW'($past(trig_level))) ^ $past(ctrl1_reg[C1_POL_BIT]))))
		else $error("samples ready trigger wrong");
endmodule // aph_host_port

/* File: logic/aph_pkg.sv */
// constants shared by the parallel host port logic
package aph_pkg;
	// ------------------------------------------------------------
	// bus and buffer sizes
	// ------------------------------------------------------------
	localparam int unsigned DATA_W     = 12;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned SYNC_W     = 4;

	// ------------------------------------------------------------
	// control word layout
	// ------------------------------------------------------------
	localparam int unsigned CW_SEL_BIT    = 10;
	localparam int unsigned CW_PAYLOAD_W  = 10;
	localparam int unsigned C0_RESET_BIT  = 0;
	localparam int unsigned C1_MODE_BIT   = 4;
	localparam int unsigned C1_POL_BIT    = 5;
	localparam int unsigned C1_TRIG_LSB   = 0;
	localparam int unsigned C1_TRIG_W     = 4;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [CW_PAYLOAD_W-1:0] CTRL0_RST = 10'h000;
	localparam logic [CW_PAYLOAD_W-1:0] CTRL1_RST = 10'h001;

	// samples_ready_output behaviour
	typedef enum logic [0:0] {
		APH_AV_NOT_EMPTY = 1'b0,
		APH_AV_TRIGGER   = 1'b1
	} aph_av_mode_t;

	// write strobe tracker
	typedef enum logic [1:0] {
		APH_WR_IDLE = 2'b00,
		APH_WR_HELD = 2'b01,
		APH_WR_DONE = 2'b10
	} aph_wr_state_t;
endpackage

/* File: verification/aph_host_model.sv */
// host bus model driving the select, read and write pins
`timescale 1ns/10ps
module aph_host_model
	import aph_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              combined,
	input  wire logic [DATA_W-1:0] dev_out,
	input  wire logic              dev_oe_n,
	output logic                   sel_a_n,
	output logic                   sel_b,
	output logic                   rd_n,
	output logic                   wr_n,
	output logic [DATA_W-1:0]      bus_in
);
	logic              drv = 1'h0;
	logic [DATA_W-1:0] hdata = '0;
	logic [DATA_W-1:0] last = '0;

	// a bus nobody drives drifts rather than holding its last level
	assign bus_in = !dev_oe_n ? dev_out : (drv ? hdata : ~last);
	always @(posedge clk) last <= bus_in;
	initial {sel_a_n, sel_b, rd_n, wr_n} = 4'hA;

	// pins = {sel_a_n, sel_b, rd_n, wr_n}
	task automatic access(
		input  logic [3:0]        pins,
		input  logic [DATA_W-1:0] d,
		input  int                hold,
		output logic [DATA_W-1:0] q,
		output logic              oe_mid,
		output logic              oe_off
	);
		@(posedge clk);
		#2;
		{sel_a_n, sel_b, wr_n} = {pins[3:2], pins[0]};
		rd_n = combined ? 1'h1 : pins[1];
		hdata = d;
		drv = !pins[0];
		repeat (hold) @(posedge clk);
		#1;
		q = bus_in;
		oe_mid = dev_oe_n;
		#1;
		// one select leaves first: the strobe must end with it alone
		sel_b = 1'h0;
		repeat (3) @(posedge clk);
		#1;
		oe_off = dev_oe_n;
		#1;
		{sel_a_n, rd_n, wr_n} = 3'h7;
		// data outlives the strobe since the write latches at its end
		repeat (3) @(posedge clk);
		#2;
		drv = 1'h0;
		repeat (2) @(posedge clk);
	endtask
endmodule // aph_host_model

/* File: verification/tb_top.sv */
// self-checking bench for the parallel host port
`timescale 1ns/10ps
module tb_top;
	import aph_pkg::*;
	logic                    clk = 1'h0;
	logic                    srst = 1'h1;
	logic                    rw_comb = 1'h0;
	logic [DATA_W-1:0]       s_data = '0;
	logic                    s_valid = 1'h0;
	wire                     sel_a_n, sel_b, rd_n, wr_n;
	wire                     oe_n, s_ready, avail, ovf;
	wire  [DATA_W-1:0]       bus_in, bus_out;
	wire  [CW_PAYLOAD_W-1:0] c0, c1;
	int                      num_errors = 0;
	int                      n_tests = 0;
	logic [15:0]             lfsr = 16'h0051;
	logic [DATA_W-1:0]       exp_q[$];
	logic [DATA_W-1:0]       last_w = '0;
	logic [CW_PAYLOAD_W-1:0] e_c0 = CTRL0_RST;
	logic [CW_PAYLOAD_W-1:0] e_c1 = CTRL1_RST;
	logic                    e_ovf = 1'h0;

	aph_host_port #(.DATA_WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_aph_host_port (
		.clk(clk), .srst(srst), .chip_select_a_n(sel_a_n),
		.chip_select_b(sel_b), .read_n(rd_n), .write_n(wr_n),
		.rw_combined(rw_comb), .parallel_data_bus_in(bus_in),
		.parallel_data_bus_out(bus_out), .parallel_data_bus_oe_n(oe_n),
		.sample_data(s_data), .sample_valid(s_valid),
		.sample_ready(s_ready), .samples_ready_output(avail),
		.overflow_flag(ovf), .ctrl0_value(c0), .ctrl1_value(c1)
	);
	aph_host_model u_aph_host_model (
		.clk(clk), .combined(rw_comb), .dev_out(bus_out),
		.dev_oe_n(oe_n), .sel_a_n(sel_a_n), .sel_b(sel_b), .rd_n(rd_n),
		.wr_n(wr_n), .bus_in(bus_in)
	);

	initial begin
		forever #12.5 clk = ~clk;
	end

	// ----------
	// helpers
	// ----------
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic is_rd(input logic [3:0] p, input logic cm);
		return cm ? (p[3:2] == 2'h1 && p[0]) : (p == 4'h5);
	endfunction
	function automatic logic is_wr(input logic [3:0] p, input logic cm);
		return cm ? (p[3:2] == 2'h1 && !p[0]) : (p == 4'h6);
	endfunction

	task automatic report_and_stop();
		if (num_errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string m);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic push(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#2;
			chk(s_ready, exp_q.size() < FIFO_DEPTH, "ready");
			lfsr = nxt(lfsr);
			s_data = lfsr[DATA_W-1:0];
			s_valid = 1'h1;
			if (exp_q.size() < FIFO_DEPTH) exp_q.push_back(s_data);
			else e_ovf = 1'h1;
		end
		@(posedge clk);
		#2;
		s_valid = 1'h0;
	endtask

	task automatic acc(input logic [3:0] p, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] q;
		logic              om;
		logic              oo;
		logic              r;
		logic              w;
		r = is_rd(p, rw_comb);
		w = is_wr(p, rw_comb);
		lfsr = nxt(lfsr);
		u_aph_host_model.access(p, d, 4 + lfsr[2:0], q, om, oo);
		#1;
		chk(om, !r, "drive enable");
		chk(oo, 1'h1, "strobe end");
		chk(oe_n, 1'h1, "bus released");
		if (r) begin
			if (exp_q.size() > 0) last_w = exp_q.pop_front();
			chk(q, last_w, "read word");
		end
		if (w && d[CW_SEL_BIT]) e_c1 = d[CW_PAYLOAD_W-1:0];
		if (w && !d[CW_SEL_BIT]) e_c0 = d[CW_PAYLOAD_W-1:0];
		if (w && !d[CW_SEL_BIT] && d[C0_RESET_BIT]) begin
			exp_q.delete();
			e_ovf = 1'h0;
		end
		chk(c0, e_c0, "ctrl0");
		chk(c1, e_c1, "ctrl1");
		chk(ovf, e_ovf, "overflow");
	endtask

	// ----------
	// main sequence
	// ----------
	initial begin
		repeat (3) @(posedge clk);
		#2;
		srst = 1'h0;
		repeat (3) @(posedge clk);
		#1;
		chk(c0, CTRL0_RST, "ctrl0 reset");
		chk(c1, CTRL1_RST, "ctrl1 reset");
		chk({oe_n, avail, ovf, s_ready}, 4'h9, "idle");
		acc(4'h6, 12'h001);
		acc(4'h6, 12'hAAE);
		acc(4'h6, 12'h400);
		push(5);
		#1;
		chk(avail, 1'h1, "available");
		for (int m = 0; m < 2; m++) begin
			@(posedge clk);
			#2;
			rw_comb = m[0];
			push(2);
			for (int i = 0; i < 16; i++) begin
				lfsr = nxt(lfsr);
				acc(i[3:0], {2'h1, lfsr[9:6], 2'h0, lfsr[3:0]});
			end
		end
		@(posedge clk);
		#2;
		rw_comb = 1'h0;
		acc(4'h6, 12'h420);
		chk(avail, 1'h0, "inverted");
		acc(4'h6, 12'h400);
		while (exp_q.size() > 0) acc(4'h5, 12'h000);
		acc(4'h5, 12'h000);
		chk(avail, 1'h0, "empty");
		push(FIFO_DEPTH + 2);
		repeat (2) @(posedge clk);
		#1;
		chk(ovf, 1'h1, "overflow set");
		acc(4'h6, 12'h001);
		chk(avail, 1'h0, "flushed");
		// threshold mode: output rises only once the fill reaches three
		acc(4'h6, 12'h413);
		push(2);
		repeat (2) @(posedge clk);
		#1;
		chk(avail, 1'h0, "below trigger");
		push(1);
		repeat (2) @(posedge clk);
		#1;
		chk(avail, 1'h1, "trigger reached");
		report_and_stop();
	end

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("[ERR] %0t run timed out", $time);
		report_and_stop();
	end
endmodule // tb_top
